/* File: core/timer_consts.svh */
// Purpose: named offsets, field positions, reset values and misc values for the timer core
// Assumes: included by bare name from every design file that needs it
// Notes: byte addresses on a 32-bit Avalon-MM slave, one aligned word each
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ==========================================================
// register byte addresses
`define ADDR_COUNT_LOW 6'h00
`define ADDR_COUNT_HIGH 6'h04
`define ADDR_TIMER_CTRL 6'h08
`define ADDR_GATE_CTRL 6'h0c
`define ADDR_IRQ_STATUS 6'h10
`define ADDR_IRQ_MASK 6'h14

// ==========================================================
// timer_control_reg fields
`define TC_ON_BIT 0
`define TC_ASYNC_BIT 1
`define TC_OSC_EN_BIT 3
`define TC_PRESCALE_LSB 4
`define TC_SOURCE_LSB 6
`define TC_RESET 8'h00

// ==========================================================
// gate_control_reg fields
`define GC_VALUE_BIT 2
`define GC_POL_BIT 6
`define GC_EN_BIT 7
`define GC_RESET 8'h00

// ==========================================================
// interrupt bits and misc values
`define IRQ_OVF_BIT 0
`define IRQ_RESET 1'h0
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hffff
`define PHASE_LAST 2'h3
`define BUS_ZERO 32'h0000_0000

`endif

/* File: core/timer_pkg.sv */
// Purpose: shared types of the timer core
// Assumes: nothing beyond the language
// Notes: clock source codes follow the two-bit source field
package timer_pkg;

   // ==========================================================
   // count clock source field
   typedef enum logic [1:0]
   {
      src_instr = 2'b00,   // instruction clock, core clock over four
      src_sys = 2'b01,     // system clock
      src_ext = 2'b10,     // pin or crystal, picked by oscillator enable
      src_cap = 2'b11      // capacitive sensing oscillator
   } clk_source_t;

endpackage

/* File: core/edge_sync.sv */
// Purpose: optional two-stage synchroniser with rising and falling edge detect
// Assumes: core_clk is the only clock; input may be treated as raw in bypass mode
// Notes: bypass shortens the path by two stages, so a mode switch can drop or add one edge
`timescale 1ns/10ps
module edge_sync
(
   input wire logic core_clk,   // core clock
   input wire logic reset,      // synchronous reset, high
   input wire logic sig_in,     // raw selected external clock
   input wire logic bypass,     // high skips the synchroniser
   output logic rise,           // one-cycle rising edge
   output logic fall            // one-cycle falling edge
);
   logic meta_q;   // first stage, read only by sync_q
   logic sync_q;   // second stage
   logic last_q;   // previous sampled level
   logic level;    // level fed to the edge detector

   // ==========================================================
   // two-flop synchroniser
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end
      else
      begin
         meta_q <= sig_in;
         sync_q <= meta_q;
      end
   end

   // bypass taps the raw pin, the synchronised path takes the second stage
   assign level = bypass ? sig_in : sync_q;

   // ==========================================================
   // edge detector on the chosen level
   always_ff @(posedge core_clk)
   begin
      if (reset)
         last_q <= 1'b0;
      else
         last_q <= level;
   end

   assign rise = level & ~last_q;
   assign fall = ~level & last_q;

endmodule

/* File: core/prescaler.sv */
// Purpose: divide a tick stream by 1, 2, 4 or 8
// Assumes: tick_in is a one-cycle pulse on core_clk
// Notes: counter is hidden from software; clear resets the phase
`timescale 1ns/10ps
module prescaler
#(
   parameter int WIDTH = 3   // bits of the divide counter, 3 at least for divide by 8
)
(
   input wire logic core_clk,           // core clock
   input wire logic reset,              // synchronous reset, high
   input wire logic clear,              // restart the divide phase
   input wire logic tick_in,            // undivided tick
   input wire logic [1:0] select,       // 0..3 gives divide by 1,2,4,8
   output logic tick_out                // divided tick, one cycle
);
   logic [WIDTH-1:0] cnt_q;   // divide counter
   logic [WIDTH-1:0] mask;    // terminal pattern for select

   // all ones in the low select bits marks the last tick of a period
   assign mask = WIDTH'((1 << select) - 1);
   assign tick_out = tick_in && ((cnt_q & mask) == mask);

   // ==========================================================
   // divide counter
   always_ff @(posedge core_clk)
   begin
      if (reset || clear)
         cnt_q <= '0;
      else if (tick_out)
         cnt_q <= '0;
      else if (tick_in)
         cnt_q <= cnt_q + WIDTH'(1);
   end

endmodule

/* File: core/timer_core.sv */
// Purpose: 16-bit gated timer/counter with prescaler, crystal enable and Avalon-MM registers
// Assumes: core_clk is the system clock; all pins are synchronous to it
// Notes: async mode samples the raw pin with no synchroniser
`timescale 1ns/10ps
`include "timer_consts.svh"
module timer_core
   import timer_pkg::*;
#(
   parameter int COUNT_W = 16,   // counter width
   parameter int PRE_W = 3       // prescale counter width
)
(
   input wire logic core_clk,                  // system clock, 20 MHz
   input wire logic reset,                     // synchronous reset, high
   input wire logic [5:0] avs_address,         // byte address
   input wire logic avs_read,                  // read request
   input wire logic avs_write,                 // write request
   input wire logic [31:0] avs_writedata,      // write data
   input wire logic [3:0] avs_byteenable,      // byte enables
   output logic [31:0] avs_readdata,           // read data
   output logic avs_waitrequest,               // high stalls the master
   input wire logic external_count_pin,        // external clock pin
   input wire logic cap_osc_clk,               // capacitive sensing oscillator
   input wire logic crystal_input_pin,         // crystal amplifier input
   output logic crystal_output_pin,            // crystal amplifier output
   output logic crystal_osc_on,                // oscillator enable to the pad cell
   input wire logic gate_input,                // count gate
   input wire logic sleep_mode,                // processor is asleep
   output logic irq                            // level interrupt
);
   // ==========================================================
   // register state
   logic [COUNT_W-1:0] count_q;    // the counter
   logic [7:0] tctrl_q;            // timer_control_reg
   logic [7:0] gctrl_q;            // gate_control_reg writable bits
   logic ovf_flag_q;               // sticky overflow_flag
   logic ovf_mask_q;               // mask for overflow_flag
   logic armed_q;                  // falling edge seen since last disarm
   logic [1:0] phase_q;            // instruction cycle phase
   logic gate_val_q;               // gate level after polarity
   logic [31:0] rdata_q;           // read data register
   logic wait_q;                   // waitrequest register
   logic irq_q;                    // interrupt register
   logic xtal_out_q;               // crystal amplifier output
   logic [31:0] rdata_d;           // next read data

   // ==========================================================
   // decoded control fields
   logic timer_on_bit;
   logic async_mode_bit;
   logic crystal_osc_enable;
   logic [1:0] prescale_select_field;
   clk_source_t clock_source_field;
   logic gate_enable_bit;
   logic gate_polarity_bit;

   assign timer_on_bit = tctrl_q[`TC_ON_BIT];
   assign async_mode_bit = tctrl_q[`TC_ASYNC_BIT];
   assign crystal_osc_enable = tctrl_q[`TC_OSC_EN_BIT];
   assign prescale_select_field = tctrl_q[`TC_PRESCALE_LSB +: 2];
   assign clock_source_field = clk_source_t'(tctrl_q[`TC_SOURCE_LSB +: 2]);
   assign gate_enable_bit = gctrl_q[`GC_EN_BIT];
   assign gate_polarity_bit = gctrl_q[`GC_POL_BIT];

   // ==========================================================
   // bus strobes: a write lands at the edge where waitrequest is low
   logic wr_go;        // write takes effect this edge
   logic wr_low;       // count_low_byte write
   logic wr_high;      // count_high_byte write
   logic count_wr;     // either count byte written
   assign wr_go = avs_write && !wait_q && avs_byteenable[0];
   assign wr_low = wr_go && (avs_address == `ADDR_COUNT_LOW);
   assign wr_high = wr_go && (avs_address == `ADDR_COUNT_HIGH);
   assign count_wr = wr_low || wr_high;

   // ==========================================================
   // clock source selection
   logic ext_sel;      // an external source is chosen
   logic ext_level;    // selected external clock level
   logic ext_rise;     // detected rising edge
   logic ext_fall;     // detected falling edge
   assign ext_sel = (clock_source_field == src_ext) || (clock_source_field == src_cap);

   // pin, crystal or capacitive oscillator
   always_comb
   begin
      unique case (clock_source_field)
         src_cap: ext_level = cap_osc_clk;
         src_ext: ext_level = crystal_osc_enable ? crystal_input_pin : external_count_pin;
         src_instr: ext_level = 1'b0;   // internal sources use no edge
         src_sys: ext_level = 1'b0;
      endcase
   end

   // synchronised or raw edges
   // the two paths differ by two cycles, so a mode switch may drop or add one edge
   edge_sync u_edge
   (
      .core_clk(core_clk),
      .reset(reset),
      .sig_in(ext_level),
      .bypass(async_mode_bit),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   // ==========================================================
   // instruction cycle phase, four core clocks per cycle
   always_ff @(posedge core_clk)
   begin
      if (reset)
         phase_q <= 2'h0;
      else
         phase_q <= phase_q + 2'h1;
   end

   // ==========================================================
   // arming for counter mode: a fall must precede the first rise
   // disarm while off covers both plain disable and high-at-disable cases
   always_ff @(posedge core_clk)
   begin
      if (reset)
         armed_q <= 1'b0;
      else if (count_wr || !timer_on_bit)
         armed_q <= 1'b0;
      else if (ext_fall)
         armed_q <= 1'b1;
   end

   // ==========================================================
   // raw tick before the prescaler
   logic raw_tick;     // undivided count clock
   logic sleep_ok;     // this source may run in sleep
   always_comb
   begin
      unique case (clock_source_field)
         src_instr: raw_tick = (phase_q == `PHASE_LAST);
         src_sys: raw_tick = 1'b1;
         src_ext: raw_tick = ext_rise && armed_q;
         src_cap: raw_tick = ext_rise && armed_q;
      endcase
   end

   // only async external counting survives sleep
   assign sleep_ok = !sleep_mode || (ext_sel && async_mode_bit);

   // ==========================================================
   // enable: on bit, gate enable, gated level and sleep_ok
   logic run;          // count enable
   logic gate_level;   // gate after polarity
   assign gate_level = gate_polarity_bit ? gate_input : !gate_input;
   assign run = timer_on_bit && (!gate_enable_bit || gate_level) && sleep_ok;

   logic pre_tick;     // prescaled tick
   logic inc;          // increment this cycle
   // divide by 1/2/4/8, cleared on count writes
   prescaler #(.WIDTH(PRE_W)) u_pre
   (
      .core_clk(core_clk),
      .reset(reset),
      .clear(count_wr),
      .tick_in(raw_tick && run),
      .select(prescale_select_field),
      .tick_out(pre_tick)
   );
   assign inc = pre_tick && !count_wr;

   // ==========================================================
   // the counter; a byte write beats an increment
   always_ff @(posedge core_clk)
   begin
      if (reset)
         count_q <= `COUNT_RESET;
      else if (wr_low)
         count_q[7:0] <= avs_writedata[7:0];
      else if (wr_high)
         count_q[15:8] <= avs_writedata[7:0];
      else if (inc)
         count_q <= count_q + COUNT_W'(1);
   end

   // ==========================================================
   // gate value status, visible even with gating off
   always_ff @(posedge core_clk)
   begin
      if (reset)
         gate_val_q <= 1'b0;
      else
         gate_val_q <= gate_level;
   end

   // ==========================================================
   // control registers
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         tctrl_q <= `TC_RESET;
         gctrl_q <= `GC_RESET;
         ovf_mask_q <= `IRQ_RESET;
      end
      else if (wr_go)
      begin
         if (avs_address == `ADDR_TIMER_CTRL)
            tctrl_q <= avs_writedata[7:0];
         if (avs_address == `ADDR_GATE_CTRL)
            gctrl_q <= avs_writedata[7:0];
         if (avs_address == `ADDR_IRQ_MASK)
            ovf_mask_q <= avs_writedata[`IRQ_OVF_BIT];
      end
   end

   // ==========================================================
   // overflow flag: set beats a write-one clear
   logic ovf_event;    // rollover this cycle
   assign ovf_event = inc && (count_q == `COUNT_MAX);
   always_ff @(posedge core_clk)
   begin
      if (reset)
         ovf_flag_q <= `IRQ_RESET;
      else if (ovf_event)
         ovf_flag_q <= 1'b1;
      else if (wr_go && (avs_address == `ADDR_IRQ_STATUS) && avs_writedata[`IRQ_OVF_BIT])
         ovf_flag_q <= 1'b0;
   end

   // level interrupt, also the wake from sleep
   always_ff @(posedge core_clk)
   begin
      if (reset)
         irq_q <= 1'b0;
      else
         irq_q <= ovf_flag_q && ovf_mask_q;
   end

   // ==========================================================
   // crystal amplifier: inverting stage, only while enabled
   always_ff @(posedge core_clk)
   begin
      if (reset)
         xtal_out_q <= 1'b0;
      else
         xtal_out_q <= crystal_osc_enable && !crystal_input_pin;
   end

   // ==========================================================
   // read mux; counter lives in this domain so a byte read is never torn
   always_comb
   begin
      rdata_d = `BUS_ZERO;
      unique case (avs_address)
         `ADDR_COUNT_LOW: rdata_d[7:0] = count_q[7:0];
         `ADDR_COUNT_HIGH: rdata_d[7:0] = count_q[15:8];
         `ADDR_TIMER_CTRL: rdata_d[7:0] = tctrl_q;
         `ADDR_GATE_CTRL:
         begin
            rdata_d[7:0] = gctrl_q;
            rdata_d[`GC_VALUE_BIT] = gate_val_q;
         end
         `ADDR_IRQ_STATUS: rdata_d[`IRQ_OVF_BIT] = ovf_flag_q;
         `ADDR_IRQ_MASK: rdata_d[`IRQ_OVF_BIT] = ovf_mask_q;
         default: rdata_d = `BUS_ZERO;             // unmapped reads zero
      endcase
   end

   // ==========================================================
   // bus handshake: one wait cycle, then waitrequest low for one edge
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wait_q <= 1'b1;
         rdata_q <= `BUS_ZERO;
      end
      else if ((avs_read || avs_write) && wait_q)
      begin
         wait_q <= 1'b0;
         rdata_q <= rdata_d;
      end
      else
         wait_q <= 1'b1;
   end

   // ==========================================================
   // outputs, all from flip-flops
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq = irq_q;
   assign crystal_output_pin = xtal_out_q;
   assign crystal_osc_on = tctrl_q[`TC_OSC_EN_BIT];

endmodule

/* File: tb/timer_core_sva.sv */
// Purpose: port-level checks of the timer core
// Assumes: one clock, synchronous active-high reset
// Notes: control and mask bytes are mirrored from accepted bus writes
`timescale 1ns/10ps
`include "timer_consts.svh"
module timer_core_sva
(
   input wire logic core_clk,              // clock
   input wire logic reset,                 // reset, high
   input wire logic [5:0] avs_address,     // byte address
   input wire logic avs_read,              // read request
   input wire logic avs_write,             // write request
   input wire logic [31:0] avs_writedata,  // write data
   input wire logic [3:0] avs_byteenable,  // byte enables
   input wire logic [31:0] avs_readdata,   // read data
   input wire logic avs_waitrequest,       // stall
   input wire logic crystal_input_pin,     // crystal return
   input wire logic crystal_output_pin,    // crystal drive
   input wire logic crystal_osc_on,        // oscillator enable
   input wire logic irq                    // level interrupt
);
   // ==========================================================
   // mirrors
   logic [7:0] ctrl_q; // last control byte written
   logic mask_q;       // last mask bit written
   logic wr_ok;        // write lands at this edge
   assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   // mirror only accepted writes, so refused ones are seen as refused
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ctrl_q <= 8'h00;
         mask_q <= 1'b0;
      end
      else
      begin
         if (wr_ok && avs_address == `ADDR_TIMER_CTRL)
            ctrl_q <= avs_writedata[7:0];
         if (wr_ok && avs_address == `ADDR_IRQ_MASK)
            mask_q <= avs_writedata[0];
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_ack;
      s_taken |=> s_answer;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer not one cycle wide");
   property p_rst;
      $fell(reset) |-> avs_waitrequest && !irq && avs_readdata == 32'h0 && !crystal_osc_on;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs wrong after reset");
   property p_high0;
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
   endproperty
   a_high0: assert property (p_high0) else $error("read data above byte not zero");
   property p_unmap;
      s_taken and avs_read && avs_address > `ADDR_IRQ_MASK |=> avs_readdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_ctrl;
      s_taken and avs_read && avs_address == `ADDR_TIMER_CTRL |=> avs_readdata[7:0] == $past(ctrl_q);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control read back wrong");
   property p_osc;
      wr_ok && avs_address == `ADDR_TIMER_CTRL |=> crystal_osc_on == $past(avs_writedata[3]);
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator enable not following write");
   property p_xtal;
      crystal_output_pin == ($past(crystal_osc_on) && !$past(crystal_input_pin));
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal drive wrong");
   property p_irq_mask;
      irq |-> $past(mask_q);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
   property p_irq_fall;
      $fell(irq) |-> $past(avs_write && !avs_waitrequest, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
endmodule

/* File: tb/ext_source_model.sv */
// Purpose: far-side model: count pin, sensing oscillator, crystal, gate
// Assumes: lines change just after core clock edges
// Notes: clock lines idle high between bursts so a burst starts with a fall
`timescale 1ns/10ps
module ext_source_model
(
   input wire logic core_clk,           // core clock
   input wire logic crystal_output_pin, // amplifier output
   output logic external_count_pin,     // count pin
   output logic cap_osc_clk,            // sensing oscillator
   output logic crystal_input_pin,      // resonator return
   output logic gate_input              // gate level
);
   initial
   begin
      external_count_pin = 1'b1;
      cap_osc_clk = 1'b1;
      crystal_input_pin = 1'b0;
      gate_input = 1'b0;
   end
   // resonator: feeds the amplifier back one cycle late, so it rings
   always @(posedge core_clk)
      crystal_input_pin <= crystal_output_pin;
   // burst of n full periods, fall first, half cycles of core clock each
   task automatic pulse(input logic use_cap, input int n, input int half);
      repeat (n)
      begin
         repeat (half) @(posedge core_clk);
         if (use_cap) cap_osc_clk <= 1'b0; else external_count_pin <= 1'b0;
         repeat (half) @(posedge core_clk);
         if (use_cap) cap_osc_clk <= 1'b1; else external_count_pin <= 1'b1;
      end
   endtask
   task automatic set_gate(input logic v);
      gate_input <= v;
   endtask
endmodule

/* File: tb/tb.sv */
// Purpose: register-level tests of the timer core
// Assumes: two-edge bus answer, control and gate layout of the core
// Notes: pipeline latency is unknown, so timed counts allow one step of slack, the crystal count two
`timescale 1ns/10ps
`include "timer_consts.svh"
module tb;
   logic core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, sleep_mode = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hf;
   logic avs_waitrequest, ecp, cap, xin, xout, xon, gate, irq;
   int bad_count = 0, checks_done = 0;
   always #25 core_clk = ~core_clk;
   timer_core i_timer_core (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .external_count_pin(ecp), .cap_osc_clk(cap), .crystal_input_pin(xin), .crystal_output_pin(xout),
      .crystal_osc_on(xon), .gate_input(gate), .sleep_mode(sleep_mode), .irq(irq));
   ext_source_model i_ext_source_model (.core_clk(core_clk), .crystal_output_pin(xout),
      .external_count_pin(ecp), .cap_osc_clk(cap), .crystal_input_pin(xin), .gate_input(gate));
   // ==========================================================
   // bus tasks: hold request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 50) bad_count++;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic chk(input string nm, input logic [5:0] a, input int e, input int tol = 0);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      checks_done++;
      if ($isunknown(q) || (q > e ? q - e : e - q) > tol)
      begin
         bad_count++;
         $display("BAD %s exp %0d got %0d", nm, e, q);
      end
   endtask
   task automatic chk_bit(input string nm, input logic g, input logic e);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic zero();
      wr(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_COUNT_HIGH, 8'h00);
   endtask
   // enabled span is k plus three edges between the two writes
   task automatic run(input logic [7:0] ctl, input int k);
      wr(`ADDR_TIMER_CTRL, ctl);
      repeat (k) @(posedge core_clk);
      wr(`ADDR_TIMER_CTRL, ctl & 8'hfe);
   endtask
   task automatic finish_test();
      if (bad_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================================
   // tests
   initial
   begin
      logic [5:0] adr [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18};
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      // gate value reads active: polarity 0 with the gate pin low counts
      foreach (adr[i]) chk("reset value", adr[i], adr[i] == `ADDR_GATE_CTRL ? (1 << `GC_VALUE_BIT) : 0);
      wr(6'h18, 8'h5a);
      chk("unmapped", 6'h18, 0);
      avs_byteenable <= 4'h0;
      wr(`ADDR_COUNT_LOW, 8'h77);
      avs_byteenable <= 4'hf;
      chk("disabled lane", `ADDR_COUNT_LOW, 0);
      wr(`ADDR_COUNT_LOW, 8'h34);
      wr(`ADDR_COUNT_HIGH, 8'h12);
      chk("low load", `ADDR_COUNT_LOW, 8'h34);
      chk("high load", `ADDR_COUNT_HIGH, 8'h12);
      // system clock through every divider; byte write restarts the divider
      for (int ps = 0; ps < 4; ps++)
      begin
         zero();
         run({2'b01, 2'(ps), 4'h1}, 61);
         chk("prescale", `ADDR_COUNT_LOW, 64 >> ps, 1);
      end
      zero();
      run(8'h01, 61);
      chk("instruction clock", `ADDR_COUNT_LOW, 16, 1);
      zero();
      run(8'h40, 61);
      chk("timer off", `ADDR_COUNT_LOW, 0);
      // gate: closed, open, then held by the other polarity
      wr(`ADDR_GATE_CTRL, 8'hc0);
      run(8'h41, 61);
      chk("gate closed", `ADDR_COUNT_LOW, 0);
      i_ext_source_model.set_gate(1'b1);
      chk("gate value", `ADDR_GATE_CTRL, 8'hc4);
      run(8'h41, 61);
      chk("gate open", `ADDR_COUNT_LOW, 64, 1);
      wr(`ADDR_GATE_CTRL, 8'h80);
      run(8'h41, 61);
      chk("gate hold", `ADDR_COUNT_LOW, 64, 1);
      wr(`ADDR_GATE_CTRL, 8'h00);
      // pin and sensing oscillator, synchronised and raw
      for (int m = 0; m < 4; m++)
      begin
         zero();
         wr(`ADDR_TIMER_CTRL, {1'b1, m[1], 4'h0, m[0], 1'b1});
         i_ext_source_model.pulse(m[1], 5, 4);
         repeat (8) @(posedge core_clk);
         wr(`ADDR_TIMER_CTRL, 8'h00);
         chk("external edges", `ADDR_COUNT_LOW, 5);
      end
      // sleep: internal clock holds, raw external keeps counting
      sleep_mode <= 1'b1;
      zero();
      run(8'h41, 61);
      chk("sleep hold", `ADDR_COUNT_LOW, 0);
      wr(`ADDR_TIMER_CTRL, 8'h83);
      chk("control readback", `ADDR_TIMER_CTRL, 8'h83);
      i_ext_source_model.pulse(1'b0, 3, 4);
      repeat (8) @(posedge core_clk);
      wr(`ADDR_TIMER_CTRL, 8'h00);
      chk("sleep count", `ADDR_COUNT_LOW, 3);
      sleep_mode <= 1'b0;
      // crystal: enable, let it settle, then count its edges
      wr(`ADDR_TIMER_CTRL, 8'h08);
      // the enable flop updates at the accepting edge, so look one edge later
      @(posedge core_clk);
      chk_bit("osc on", xon, 1'b1);
      repeat (40) @(posedge core_clk);
      zero();
      run(8'h89, 61);
      chk("crystal count", `ADDR_COUNT_LOW, 16, 2);
      wr(`ADDR_TIMER_CTRL, 8'h00);
      @(posedge core_clk);
      chk_bit("osc off", xon, 1'b0);
      // rollover, mask and clear of the interrupt
      wr(`ADDR_IRQ_MASK, 8'h01);
      wr(`ADDR_COUNT_LOW, 8'hff);
      wr(`ADDR_COUNT_HIGH, 8'hff);
      run(8'h41, 4);
      chk("overflow flag", `ADDR_IRQ_STATUS, 1);
      chk_bit("irq set", irq, 1'b1);
      wr(`ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge core_clk);
      chk_bit("irq masked", irq, 1'b0);
      wr(`ADDR_IRQ_MASK, 8'h01);
      repeat (2) @(posedge core_clk);
      chk_bit("irq unmasked", irq, 1'b1);
      wr(`ADDR_IRQ_STATUS, 8'h01);
      chk("flag cleared", `ADDR_IRQ_STATUS, 0);
      chk_bit("irq cleared", irq, 1'b0);
      finish_test();
   end
   // watchdog well beyond the roughly 1300 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      finish_test();
   end
endmodule
bind timer_core timer_core_sva i_timer_core_sva (.core_clk(core_clk), .reset(reset),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .crystal_input_pin(crystal_input_pin), .crystal_output_pin(crystal_output_pin),
   .crystal_osc_on(crystal_osc_on), .irq(irq));
